/* tsp_pkg.sv */
// shared constants and types for the test signal probe multiplexer
package tsp_pkg;

    // apb register byte offsets
    localparam logic [7:0] TSP_OFS_ANALOG = 8'h00;
    localparam logic [7:0] TSP_OFS_DIGITAL = 8'h04;
    localparam logic [7:0] TSP_OFS_MONCTL = 8'h08;
    localparam logic [7:0] TSP_OFS_STATUS = 8'h0c;
    localparam int TSP_ADDR_W = 8;
    localparam int TSP_DATA_W = 32;

    // reset values
    localparam logic [7:0] TSP_RST_ANALOG = 8'h00;
    localparam logic [7:0] TSP_RST_DIGITAL = 8'h00;
    localparam logic [3:0] TSP_RST_MONCTL = 4'h0;

    // field layout
    localparam int TSP_ANA_CODE_W = 5;
    localparam int TSP_DIG_CODE_W = 7;
    localparam int TSP_SER_SEL_W = 3;
    localparam int TSP_MON_ROUTE_BIT = 3;
    localparam int TSP_ST_PIN_BIT = 0;
    localparam int TSP_ST_ANA_RSV_BIT = 1;
    localparam int TSP_ST_DIG_UNLISTED_BIT = 2;
    localparam int TSP_ST_DIG_ACTIVE_BIT = 3;
    localparam int TSP_ST_DIG_SRC_LSB = 4;
    localparam int TSP_ST_SER_SRC_LSB = 13;

    // analog probe codes, one per defined node
    localparam int TSP_ANA_NODES = 13;
    localparam logic [4:0] TSP_ANA_MID_SUPPLY = 5'h00;
    localparam logic [4:0] TSP_ANA_BANDGAP = 5'h01;
    localparam logic [4:0] TSP_ANA_DEMOD_I = 5'h02;
    localparam logic [4:0] TSP_ANA_DEMOD_Q = 5'h03;
    localparam logic [4:0] TSP_ANA_SUBAMP_I = 5'h04;
    localparam logic [4:0] TSP_ANA_SUBAMP_Q = 5'h05;
    localparam logic [4:0] TSP_ANA_NCORR_I = 5'h06;
    localparam logic [4:0] TSP_ANA_NCORR_Q = 5'h07;
    localparam logic [4:0] TSP_ANA_DCORR_I = 5'h08;
    localparam logic [4:0] TSP_ANA_DCORR_Q = 5'h09;
    localparam logic [4:0] TSP_ANA_EVAL_L = 5'h0a;
    localparam logic [4:0] TSP_ANA_EVAL_R = 5'h0b;
    localparam logic [4:0] TSP_ANA_TEMP = 5'h0c;
    localparam logic [4:0] TSP_ANA_FIRST_RSV = 5'h0d;

    // digital probe codes, compared against the whole register byte
    localparam logic [7:0] TSP_DIG_NONE = 8'h00;
    localparam logic [7:0] TSP_DIG_RX_DATA = 8'hf4;
    localparam logic [7:0] TSP_DIG_RX_VALID = 8'he4;
    localparam logic [7:0] TSP_DIG_RX_COLL = 8'hd4;
    localparam logic [7:0] TSP_DIG_SER_CLK = 8'hc4;
    localparam logic [7:0] TSP_DIG_RD_STROBE = 8'hb5;
    localparam logic [7:0] TSP_DIG_WR_STROBE = 8'ha5;
    localparam logic [7:0] TSP_DIG_CORE_CLK = 8'h96;
    localparam logic [7:0] TSP_DIG_PSK_OUT = 8'h83;
    localparam logic [7:0] TSP_DIG_PSK_AMP = 8'he2;

    // serial monitor selector values
    localparam logic [2:0] TSP_SER_LOW = 3'h0;
    localparam logic [2:0] TSP_SER_HIGH = 3'h1;
    localparam logic [2:0] TSP_SER_ENVELOPE = 3'h2;
    localparam logic [2:0] TSP_SER_TX_NRZ = 3'h3;
    localparam logic [2:0] TSP_SER_MANCH_SUB = 3'h4;
    localparam logic [2:0] TSP_SER_MANCH = 3'h5;

    typedef struct packed {
        logic rx_data;
        logic rx_valid;
        logic rx_coll;
        logic ser_clk;
        logic rd_strobe;
        logic wr_strobe;
        logic core_clk;
        logic phase_shift_output;
        logic phase_shift_amplitude_seen;
    } tsp_dig_src_t;

    typedef struct packed {
        logic envelope;
        logic tx_nrz;
        logic manch_sub;
        logic manch;
    } tsp_ser_src_t;

    localparam int TSP_SRC_W = $bits(tsp_dig_src_t) + $bits(tsp_ser_src_t);

endpackage

/* tsp_probe_mux.sv */
// test signal probe multiplexer with apb register slave
//
// Functional notes
// - aux pin node follows the 5-bit analog probe code
// - analog codes 0..3: mid supply, bandgap, demod i, demod q
// - codes 4,5 subcarrier amps; 6..9 n and d correlators i/q
// - codes a,b,c: left eval, right eval, temperature voltage
// - analog code d and above select no node
// - digital probe reaches monitor pin only with route enable set
// - digital probe chosen by the digital probe select register
// - f4 rx data, e4 rx valid, d4 rx collision
// - c4 internal serial bit clock
// - b5 synced read strobe, a5 synced write strobe
// - 96 core clock
// - 83 phase shift output, e2 phase shift amplitude seen
// - code 00 falls back to the serial monitor selector
// - serial selector 0..5 low/high/env/nrz/manch sub/manch; 6,7 low
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module tsp_probe_mux
    import tsp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TSP_ADDR_W-1:0] paddr,
    input wire logic [TSP_DATA_W-1:0] pwdata,
    output logic [TSP_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tsp_dig_src_t dig_src,
    input wire tsp_ser_src_t ser_src,
    output logic [TSP_ANA_NODES-1:0] aux_node_sel,
    output logic [TSP_ANA_CODE_W-1:0] analog_probe_code,
    output logic monitor_output_pin
);

    // register state
    logic [7:0] analog_probe_select_q;
    logic [7:0] analog_probe_select_d;
    logic [7:0] digital_probe_select_q;
    logic [7:0] digital_probe_select_d;
    logic [TSP_SER_SEL_W-1:0] serial_monitor_selector_q;
    logic [TSP_SER_SEL_W-1:0] serial_monitor_selector_d;
    logic probe_route_enable_q;
    logic probe_route_enable_d;

    // bus state
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [TSP_DATA_W-1:0] prdata_q;
    logic [TSP_DATA_W-1:0] prdata_d;

    // observation outputs
    logic [TSP_ANA_NODES-1:0] aux_sel_q;
    logic [TSP_ANA_NODES-1:0] aux_sel_d;
    logic mon_pin_q;
    logic mon_pin_d;

    // synchronised sources
    logic [TSP_SRC_W-1:0] src_sync;
    tsp_dig_src_t dig_s;
    tsp_ser_src_t ser_s;

    // decode helpers
    logic access_first;
    logic access_done;
    logic wr_done;
    logic addr_hit;
    logic [TSP_DATA_W-1:0] rd_value;
    logic [TSP_DATA_W-1:0] ctl_word;
    logic [TSP_DATA_W-1:0] status_word;
    logic dig_listed;
    logic dig_sel;
    logic ser_sel;
    logic ana_reserved;
    logic [TSP_ANA_CODE_W-1:0] ana_code;

    // sources come from the core clock domain, so resample first
    tsp_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({dig_src, ser_src}),
        .sync_out(src_sync)
    );

    assign dig_s = tsp_dig_src_t'(src_sync[TSP_SRC_W-1:$bits(tsp_ser_src_t)]);
    assign ser_s = tsp_ser_src_t'(src_sync[$bits(tsp_ser_src_t)-1:0]);

    // apb phase tracking: one wait state on every access
    assign access_first = psel & penable & ~pready_q;
    assign access_done = psel & penable & pready_q;
    assign wr_done = access_done & pwrite & addr_hit;

    always_comb begin
        addr_hit = 1'b0;
        case (paddr)
            TSP_OFS_ANALOG: addr_hit = 1'b1;
            TSP_OFS_DIGITAL: addr_hit = 1'b1;
            TSP_OFS_MONCTL: addr_hit = 1'b1;
            TSP_OFS_STATUS: addr_hit = ~pwrite;
            default: addr_hit = 1'b0;
        endcase
    end

    // listed codes are full bytes, wider than the seven-bit code field
    assign ana_code = analog_probe_select_q[TSP_ANA_CODE_W-1:0];

    always_comb begin
        case (digital_probe_select_q)
            TSP_DIG_NONE: dig_listed = 1'b1;
            TSP_DIG_RX_DATA: dig_listed = 1'b1;
            TSP_DIG_RX_VALID: dig_listed = 1'b1;
            TSP_DIG_RX_COLL: dig_listed = 1'b1;
            TSP_DIG_SER_CLK: dig_listed = 1'b1;
            TSP_DIG_RD_STROBE: dig_listed = 1'b1;
            TSP_DIG_WR_STROBE: dig_listed = 1'b1;
            TSP_DIG_CORE_CLK: dig_listed = 1'b1;
            TSP_DIG_PSK_OUT: dig_listed = 1'b1;
            TSP_DIG_PSK_AMP: dig_listed = 1'b1;
            default: dig_listed = 1'b0;
        endcase
    end

    // unlisted codes are production-only; flagged, never trapped
    assign ana_reserved = (ana_code >= TSP_ANA_FIRST_RSV);

    // host view of the monitor control register
    always_comb begin
        ctl_word = '0;
        ctl_word[TSP_SER_SEL_W-1:0] = serial_monitor_selector_q;
        ctl_word[TSP_MON_ROUTE_BIT] = probe_route_enable_q;
    end

    // live status: pin level, decode flags and resynchronised sources
    always_comb begin
        status_word = '0;
        status_word[TSP_ST_PIN_BIT] = mon_pin_q;
        status_word[TSP_ST_ANA_RSV_BIT] = ana_reserved;
        status_word[TSP_ST_DIG_UNLISTED_BIT] = ~dig_listed;
        status_word[TSP_ST_DIG_ACTIVE_BIT] = dig_sel;
        status_word[TSP_ST_SER_SRC_LSB-1:TSP_ST_DIG_SRC_LSB] = dig_s;
        status_word[TSP_ST_SER_SRC_LSB+$bits(tsp_ser_src_t)-1:
            TSP_ST_SER_SRC_LSB] = ser_s;
    end

    // read mux
    always_comb begin
        rd_value = '0;
        case (paddr)
            TSP_OFS_ANALOG: rd_value[7:0] = analog_probe_select_q;
            TSP_OFS_DIGITAL: rd_value[7:0] = digital_probe_select_q;
            TSP_OFS_MONCTL: rd_value = ctl_word;
            TSP_OFS_STATUS: rd_value = status_word;
            default: rd_value = '0;
        endcase
    end

    // bus next-state
    always_comb begin
        pready_d = access_first;
        pslverr_d = access_first & ~addr_hit;
        prdata_d = prdata_q;
        if (access_first) begin
            prdata_d = (addr_hit & ~pwrite) ? rd_value : '0;
        end
    end

    // register next-state; writes land only at the completing edge
    always_comb begin
        analog_probe_select_d = analog_probe_select_q;
        digital_probe_select_d = digital_probe_select_q;
        serial_monitor_selector_d = serial_monitor_selector_q;
        probe_route_enable_d = probe_route_enable_q;
        if (wr_done) begin
            case (paddr)
                TSP_OFS_ANALOG: begin
                    analog_probe_select_d = pwdata[7:0];
                end
                TSP_OFS_DIGITAL: begin
                    digital_probe_select_d = pwdata[7:0];
                end
                TSP_OFS_MONCTL: begin
                    serial_monitor_selector_d = pwdata[TSP_SER_SEL_W-1:0];
                    probe_route_enable_d = pwdata[TSP_MON_ROUTE_BIT];
                end
                default: begin
                    analog_probe_select_d = analog_probe_select_q;
                end
            endcase
        end
    end

    // analog node one-hot: one enable per defined node, none for codes d+
    genvar gi;
    generate
        for (gi = 0; gi < TSP_ANA_NODES; gi++) begin : g_ana
            assign aux_sel_d[gi] =
                (ana_code == TSP_ANA_CODE_W'(gi)) & ~ana_reserved;
        end
    endgenerate

    // serial monitor selector, the pin source whenever no probe is routed
    always_comb begin
        ser_sel = 1'b0;
        case (serial_monitor_selector_q)
            TSP_SER_LOW: ser_sel = 1'b0;
            TSP_SER_HIGH: ser_sel = 1'b1;
            TSP_SER_ENVELOPE: ser_sel = ser_s.envelope;
            TSP_SER_TX_NRZ: ser_sel = ser_s.tx_nrz;
            TSP_SER_MANCH_SUB: ser_sel = ser_s.manch_sub;
            TSP_SER_MANCH: ser_sel = ser_s.manch;
            default: ser_sel = 1'b0; // reserved values hold the pin low
        endcase
    end

    // digital probe path
    always_comb begin
        dig_sel = probe_route_enable_q &
            (digital_probe_select_q != TSP_DIG_NONE);
        // mux tracks register contents directly, no arming step
        mon_pin_d = ser_sel;
        if (dig_sel) begin
            case (digital_probe_select_q)
                TSP_DIG_RX_DATA: mon_pin_d = dig_s.rx_data;
                TSP_DIG_RX_VALID: mon_pin_d = dig_s.rx_valid;
                TSP_DIG_RX_COLL: mon_pin_d = dig_s.rx_coll;
                TSP_DIG_SER_CLK: mon_pin_d = dig_s.ser_clk;
                TSP_DIG_RD_STROBE: mon_pin_d = dig_s.rd_strobe;
                TSP_DIG_WR_STROBE: mon_pin_d = dig_s.wr_strobe;
                // sampled clock aliases at 100 mhz; coarse view only
                TSP_DIG_CORE_CLK: mon_pin_d = dig_s.core_clk;
                TSP_DIG_PSK_OUT: begin
                    mon_pin_d = dig_s.phase_shift_output;
                end
                TSP_DIG_PSK_AMP: begin
                    mon_pin_d = dig_s.phase_shift_amplitude_seen;
                end
                // production codes: pin held low, host must avoid them
                default: mon_pin_d = 1'b0;
            endcase
        end
    end

    // host-visible registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_probe_select_q <= TSP_RST_ANALOG;
            digital_probe_select_q <= TSP_RST_DIGITAL;
            serial_monitor_selector_q <= TSP_RST_MONCTL[TSP_SER_SEL_W-1:0];
            probe_route_enable_q <= TSP_RST_MONCTL[TSP_MON_ROUTE_BIT];
        end else begin
            analog_probe_select_q <= analog_probe_select_d;
            digital_probe_select_q <= digital_probe_select_d;
            serial_monitor_selector_q <= serial_monitor_selector_d;
            probe_route_enable_q <= probe_route_enable_d;
        end
    end

    // bus response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // pin outputs registered, so a decode change never glitches a pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_sel_q <= '0;
            mon_pin_q <= 1'b0;
        end else begin
            aux_sel_q <= aux_sel_d;
            mon_pin_q <= mon_pin_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign aux_node_sel = aux_sel_q;
    assign analog_probe_code = ana_code;
    assign monitor_output_pin = mon_pin_q;

endmodule // tsp_probe_mux
`default_nettype wire

/* tsp_probe_mux_chk.sv */
// assertion checker for the probe multiplexer ports
`timescale 1ns/10ps
`default_nettype none
module tsp_probe_mux_chk
    import tsp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TSP_ADDR_W-1:0] paddr,
    input wire logic [TSP_DATA_W-1:0] pwdata,
    input wire logic [TSP_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tsp_dig_src_t dig_src,
    input wire tsp_ser_src_t ser_src,
    input wire logic [TSP_ANA_NODES-1:0] aux_node_sel,
    input wire logic [TSP_ANA_CODE_W-1:0] analog_probe_code,
    input wire logic monitor_output_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic [1:0] live_q, live_d;
    logic [7:0] ana_q, ana_d, dig_q, dig_d;
    logic [3:0] ctl_q, ctl_d;
    logic [12:0] s1_q, s2_q;
    logic ser_q, ser_d, sel_q, sel_d;
    // shadow registers rebuilt from completed writes
    always_comb begin
        wr = psel && penable && pready && pwrite;
        live_d = {live_q[0], 1'b1};
        ana_d = (wr && paddr == TSP_OFS_ANALOG) ? pwdata[7:0] : ana_q;
        dig_d = (wr && paddr == TSP_OFS_DIGITAL) ? pwdata[7:0] : dig_q;
        ctl_d = (wr && paddr == TSP_OFS_MONCTL) ? pwdata[3:0] : ctl_q;
        ser_d = ctl_q[2:0] == 3'h1 || (ctl_q[2:0] inside {[3'h2:3'h5]}
            && s2_q[3'h5 - ctl_q[2:0]]);
        case (dig_q)
            TSP_DIG_RX_DATA: sel_d = s2_q[12];
            TSP_DIG_RX_VALID: sel_d = s2_q[11];
            TSP_DIG_RX_COLL: sel_d = s2_q[10];
            TSP_DIG_SER_CLK: sel_d = s2_q[9];
            TSP_DIG_RD_STROBE: sel_d = s2_q[8];
            TSP_DIG_WR_STROBE: sel_d = s2_q[7];
            TSP_DIG_CORE_CLK: sel_d = s2_q[6];
            TSP_DIG_PSK_OUT: sel_d = s2_q[5];
            TSP_DIG_PSK_AMP: sel_d = s2_q[4];
            default: sel_d = 1'b0;
        endcase
    end
    // two sync stages mirror the source latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_q <= '0;
            ana_q <= '0;
            dig_q <= '0;
            ctl_q <= '0;
            s1_q <= '0;
            s2_q <= '0;
            ser_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            live_q <= live_d;
            ana_q <= ana_d;
            dig_q <= dig_d;
            ctl_q <= ctl_d;
            s1_q <= {dig_src, ser_src};
            s2_q <= s1_q;
            ser_q <= ser_d;
            sel_q <= sel_d;
        end
    end
    property p_code_write;
        wr && paddr == TSP_OFS_ANALOG |=>
            analog_probe_code == $past(pwdata[4:0]);
    endproperty
    a_code_write: assert property (p_code_write)
        else $error("analog code does not follow write");
    property p_aux_node;
        live_q[1] && $past(ana_q[4:0]) < TSP_ANA_FIRST_RSV |->
            aux_node_sel == (13'h1 << $past(ana_q[4:0]));
    endproperty
    a_aux_node: assert property (p_aux_node)
        else $error("aux node select wrong");
    property p_aux_rsv;
        live_q[1] && $past(ana_q[4:0]) >= TSP_ANA_FIRST_RSV |->
            aux_node_sel == '0;
    endproperty
    a_aux_rsv: assert property (p_aux_rsv)
        else $error("reserved analog code selects a node");
    property p_serial;
        live_q[1] && !$past(ctl_q[3]) |-> monitor_output_pin == ser_q;
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial monitor source wrong");
    property p_digital;
        live_q[1] && $past(ctl_q[3]) && $past(dig_q) != TSP_DIG_NONE |->
            monitor_output_pin == sel_q;
    endproperty
    a_digital: assert property (p_digital)
        else $error("digital probe source wrong");
    property p_no_probe;
        live_q[1] && $past(ctl_q[3]) && $past(dig_q) == TSP_DIG_NONE |->
            monitor_output_pin == ser_q;
    endproperty
    a_no_probe: assert property (p_no_probe)
        else $error("code zero does not fall back to serial");
    property p_wait;
        psel && penable && !$past(penable) |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait)
        else $error("access not answered after one wait state");
    property p_single;
        pready |=> !pready;
    endproperty
    a_single: assert property (p_single)
        else $error("ready held longer than one cycle");
    c_rx_route: cover property (ctl_q[3] && dig_q == TSP_DIG_RX_DATA
        && monitor_output_pin);
    c_aux_rsv: cover property (ana_q[4:0] >= TSP_ANA_FIRST_RSV);
    c_slverr: cover property (pready && pslverr);
endmodule // tsp_probe_mux_chk
`default_nettype wire

/* tsp_probe_mux_tb.sv */
// self-checking bench for the probe multiplexer
`timescale 1ns/10ps
`default_nettype none
module tsp_probe_mux_tb
    import tsp_pkg::*;
;
    typedef struct packed {
        logic [7:0] dig;
        logic [3:0] ctl;
        logic [12:0] src;
        logic pin;
    } tsp_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [12:0] src = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, seen_pin, monitor_output_pin;
    logic [12:0] aux_node_sel, seen_aux;
    logic [4:0] analog_probe_code;
    int miscompares = 0;
    int n_compared = 0;
    tsp_row_t rows [21] = '{
        '{8'hf4, 4'h8, 13'h1000, 1'b1},
        '{8'he4, 4'h8, 13'h0800, 1'b1},
        '{8'hd4, 4'h8, 13'h0400, 1'b1},
        '{8'hc4, 4'h8, 13'h0200, 1'b1},
        '{8'hb5, 4'h8, 13'h0100, 1'b1},
        '{8'ha5, 4'h8, 13'h0080, 1'b1},
        '{8'h96, 4'h8, 13'h0040, 1'b1},
        '{8'h83, 4'h8, 13'h0020, 1'b1},
        '{8'he2, 4'h8, 13'h0010, 1'b1},
        '{8'hf4, 4'h8, 13'h0fff, 1'b0},
        '{8'hf4, 4'h0, 13'h1000, 1'b0},
        '{8'h11, 4'h8, 13'h1fff, 1'b0},
        '{8'h00, 4'h9, 13'h1fff, 1'b1},
        '{8'h00, 4'h8, 13'h1fff, 1'b0},
        '{8'h00, 4'h1, 13'h0000, 1'b1},
        '{8'h00, 4'h2, 13'h0008, 1'b1},
        '{8'h00, 4'h3, 13'h0004, 1'b1},
        '{8'h00, 4'h4, 13'h0002, 1'b1},
        '{8'h00, 4'h5, 13'h0001, 1'b1},
        '{8'h00, 4'h6, 13'h1fff, 1'b0},
        '{8'h00, 4'h7, 13'h1fff, 1'b0}};
    always #5 pclk = ~pclk;
    tsp_probe_mux u_tsp_probe_mux (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .dig_src(tsp_dig_src_t'(src[12:4])),
        .ser_src(tsp_ser_src_t'(src[3:0])),
        .aux_node_sel(aux_node_sel), .analog_probe_code(analog_probe_code),
        .monitor_output_pin(monitor_output_pin));
    tsp_scope u_tsp_scope (
        .pclk(pclk), .monitor_output_pin(monitor_output_pin),
        .aux_node_sel(aux_node_sel), .seen_pin(seen_pin),
        .seen_aux(seen_aux));
    task automatic check(input string name, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // released for one cycle, so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) check("pready", 32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic test_done;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, TSP_OFS_DIGITAL, 32'h0);
        check("digital reset", rd, 32'h0);
        apb(1'b0, TSP_OFS_MONCTL, 32'h0);
        check("monctl reset", rd, 32'h0);
        for (int i = 0; i < 21; i++) begin
            apb(1'b1, TSP_OFS_DIGITAL, {24'h0, rows[i].dig});
            apb(1'b1, TSP_OFS_MONCTL, {28'h0, rows[i].ctl});
            src <= rows[i].src;
            repeat (5) @(posedge pclk);
            check("pin", 32'(seen_pin), 32'(rows[i].pin));
        end
        apb(1'b1, TSP_OFS_DIGITAL, 32'h11);
        apb(1'b1, TSP_OFS_MONCTL, 32'hfffffff9);
        repeat (2) @(posedge pclk);
        check("pin unlisted", 32'(seen_pin), 32'h0);
        apb(1'b0, TSP_OFS_MONCTL, 32'h0);
        check("monctl rw", rd, 32'h9);
        apb(1'b0, TSP_OFS_STATUS, 32'h0);
        check("status unlisted", rd, 32'h0001fffc);
        apb(1'b1, TSP_OFS_DIGITAL, 32'h0);
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, TSP_OFS_ANALOG, 32'(i));
            repeat (2) @(posedge pclk);
            check("aux", 32'(seen_aux), i < 13 ? 32'h1 << i : 0);
            check("code", 32'(analog_probe_code), 32'(i));
        end
        // upper bits are not stored
        apb(1'b1, TSP_OFS_ANALOG, 32'hffffffff);
        apb(1'b0, TSP_OFS_ANALOG, 32'h0);
        check("analog rw", rd, 32'h000000ff);
        apb(1'b0, TSP_OFS_STATUS, 32'h0);
        check("status reserved", rd, 32'h0001fff3);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, TSP_OFS_STATUS, 32'h0);
        check("status write err", 32'(err), 32'h1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("reset pin", 32'(monitor_output_pin), 32'h0);
        check("reset aux", 32'(aux_node_sel), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, TSP_OFS_ANALOG, 32'h0);
        check("analog after reset", rd, 32'h0);
        test_done();
    end
endmodule // tsp_probe_mux_tb
bind tsp_probe_mux tsp_probe_mux_chk u_tsp_probe_mux_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dig_src(dig_src),
    .ser_src(ser_src), .aux_node_sel(aux_node_sel),
    .analog_probe_code(analog_probe_code),
    .monitor_output_pin(monitor_output_pin));
`default_nettype wire

/* tsp_scope.sv */
// bench instrument capturing both test pins each cycle
`timescale 1ns/10ps
`default_nettype none
module tsp_scope
    import tsp_pkg::*;
(
    input wire logic pclk,
    input wire logic monitor_output_pin,
    input wire logic [TSP_ANA_NODES-1:0] aux_node_sel,
    output logic seen_pin,
    output logic [TSP_ANA_NODES-1:0] seen_aux
);
    // a probe only samples, it never loads the pins
    always_ff @(posedge pclk) begin
        seen_pin <= monitor_output_pin;
        seen_aux <= aux_node_sel;
    end
endmodule // tsp_scope
`default_nettype wire

/* tsp_sync.sv */
// two flip-flop synchroniser bank for the observed signals
`timescale 1ns/10ps
`default_nettype none
module tsp_sync
    import tsp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [TSP_SRC_W-1:0] async_in,
    output logic [TSP_SRC_W-1:0] sync_out
);

    logic [TSP_SRC_W-1:0] meta_q;
    logic [TSP_SRC_W-1:0] meta_d;
    logic [TSP_SRC_W-1:0] sync_q;
    logic [TSP_SRC_W-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // tsp_sync
`default_nettype wire
